// file: pkg/qdl_cfg.svh
// Contract
// - shift register is enabled only while active-low frame select is low
// - serial data sampled only on falling serial clock edges after frame select falls
// - 24-bit input shift register, one bit per falling serial clock edge
// - completed frame acts only after the 24th falling edge; addressed channel updates (code updates only its pending value unless word bit 20 is set)
// - frame select rising before the 24th edge aborts; partial word discarded
// - active-high reset forces all channels to zero-scale or mid-scale by select
// - data is straight binary when select low, two's complement when high
// - serial port is ignored unless active-low interface enable is low
// - rising edge of load strobe transfers pending values to all channels at once
`ifndef QDL_CFG_SVH
`define QDL_CFG_SVH
`define QDL_FRAME_BITS   24
`define QDL_CNT_W        5
`define QDL_CNT_LAST     5'h17
`define QDL_DATA_W       16
`define QDL_CHAN_N       4
`define QDL_CHAN_W       2
`define QDL_ADDR_MSB     18
`define QDL_ADDR_LSB     17
`define QDL_LOAD_BIT     20
`define QDL_DATA_MSB     15
`define QDL_ZERO_BIN     16'h0000
`define QDL_MID_BIN      16'h8000
`define QDL_ZERO_TWOS    16'h8000
`define QDL_MID_TWOS     16'h0000
`define QDL_INIT_CNT     2'h3
`endif

// file: pkg/qdl_pkg.sv
package qdl_pkg;
    typedef enum logic [0:0] {
        QDL_IDLE  = 1'b0,
        QDL_SHIFT = 1'b1
    } qdl_state_t;

    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic din;
        logic enable_n;
        logic load;
    } qdl_pins_t;

    typedef struct packed {
        logic        commit;
        logic        load_now;
        logic [1:0]  chan;
        logic [15:0] data;
    } qdl_word_t;
endpackage : qdl_pkg

// file: logic/qdl_chan_mem.sv
`timescale 1ns/1ps
`include "qdl_cfg.svh"
module qdl_chan_mem #(
    parameter int DW = `QDL_DATA_W,
    parameter int N  = `QDL_CHAN_N
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  reset_scale_select,
    // pending write
    input  wire logic                  wr_en,
    input  wire logic [$clog2(N)-1:0]  wr_chan,
    input  wire logic [DW-1:0]         wr_data,
    input  wire logic                  wr_load_now,
    // load all
    input  wire logic                  load_all,
    // outputs
    output logic      [N*DW-1:0]       chan_q
);
    typedef struct packed {
        logic [N*DW-1:0] pend;
        logic [N*DW-1:0] act;
        logic [1:0]      init;
    } qdl_mem_state_t;

    qdl_mem_state_t s_q;
    qdl_mem_state_t s_d;

    // reset scale per select pin; binary offset view of both codings
    function automatic logic [DW-1:0] reset_code(input logic sel);
        reset_code = sel ? DW'(`QDL_MID_BIN) : DW'(`QDL_ZERO_BIN);
    endfunction : reset_code

    // two's complement input is turned to offset binary
    function automatic logic [DW-1:0] to_bin(input logic sel, input logic [DW-1:0] v);
        to_bin = sel ? {~v[DW-1], v[DW-2:0]} : v;
    endfunction : to_bin

    always_comb begin
        s_d = s_q;
        // reset code is reapplied until the select synchroniser has settled
        if (s_q.init != 2'h0) begin
            s_d.init = s_q.init - 2'h1;
            for (int i = 0; i < N; i++) begin
                s_d.pend[i*DW +: DW] = reset_code(reset_scale_select);
                s_d.act[i*DW +: DW]  = reset_code(reset_scale_select);
            end
        end else begin
            if (wr_en) begin
                s_d.pend[wr_chan*DW +: DW] = to_bin(reset_scale_select, wr_data);
                if (wr_load_now) begin
                    s_d.act[wr_chan*DW +: DW] = to_bin(reset_scale_select, wr_data);
                end
            end
            if (load_all) begin
                s_d.act = s_d.pend;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{pend: '0, act: '0, init: `QDL_INIT_CNT};
        end else begin
            s_q <= s_d;
        end
    end

    assign chan_q = s_q.act;
endmodule : qdl_chan_mem

// file: logic/qdl_port.sv
`timescale 1ns/1ps
`include "qdl_cfg.svh"
module qdl_port #(
    parameter int DW = `QDL_DATA_W,
    parameter int N  = `QDL_CHAN_N
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // serial pins
    input  wire logic             sclk,
    input  wire logic             sync_n,
    input  wire logic             din,
    input  wire logic             enable_n,
    input  wire logic             load_all_channels,
    input  wire logic             reset_scale_select,
    // channel values, offset binary
    output logic      [N*DW-1:0]  chan_value,
    output logic                  frame_done,
    output logic                  frame_abort
);
    typedef struct packed {
        qdl_pkg::qdl_pins_t      m1;
        qdl_pkg::qdl_pins_t      m2;
        qdl_pkg::qdl_pins_t      prev;
        logic                    sel1;
        logic                    sel2;
        qdl_pkg::qdl_state_t     st;
        logic [`QDL_CNT_W-1:0]   cnt;
        logic [23:0]             shreg;
        qdl_pkg::qdl_word_t      word;
        logic                    done;
        logic                    abort;
        logic                    ld;
    } qdl_port_state_t;

    qdl_port_state_t s_q;
    qdl_port_state_t s_d;
    qdl_pkg::qdl_pins_t pins_in;

    assign pins_in = '{sclk: sclk, sync_n: sync_n, din: din,
                       enable_n: enable_n, load: load_all_channels};

    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction : fell

    always_comb begin
        s_d = s_q;
        s_d.m1 = pins_in;
        s_d.m2 = s_q.m1;
        s_d.prev = s_q.m2;
        s_d.sel1 = reset_scale_select;
        s_d.sel2 = s_q.sel1;
        s_d.word.commit = 1'b0;
        s_d.done = 1'b0;
        s_d.abort = 1'b0;
        s_d.ld = ~s_q.prev.load & s_q.m2.load;
        unique case (s_q.st)
            qdl_pkg::QDL_IDLE: begin
                if (fell(s_q.prev.sync_n, s_q.m2.sync_n) && !s_q.m2.enable_n) begin
                    s_d.st  = qdl_pkg::QDL_SHIFT;
                    s_d.cnt = '0;
                end
            end
            qdl_pkg::QDL_SHIFT: begin
                if (s_q.m2.sync_n || s_q.m2.enable_n) begin
                    s_d.st    = qdl_pkg::QDL_IDLE;
                    s_d.abort = 1'b1;
                end else if (fell(s_q.prev.sclk, s_q.m2.sclk)) begin
                    s_d.shreg = {s_q.shreg[22:0], s_q.m2.din};
                    s_d.cnt   = s_q.cnt + `QDL_CNT_W'(1);
                    if (s_q.cnt == `QDL_CNT_LAST) begin
                        s_d.st = qdl_pkg::QDL_IDLE;
                        s_d.done = 1'b1;
                        s_d.word.commit = 1'b1;
                        s_d.word.load_now = s_q.shreg[`QDL_LOAD_BIT - 1];
                        s_d.word.chan = s_q.shreg[`QDL_ADDR_MSB-1:`QDL_ADDR_LSB-1];
                        s_d.word.data = {s_q.shreg[`QDL_DATA_MSB-1:0], s_q.m2.din};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{m1: 5'h1e, m2: 5'h1e, prev: 5'h1e, st: qdl_pkg::QDL_IDLE,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    qdl_chan_mem #(.DW(DW), .N(N)) u_mem (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .reset_scale_select (s_q.sel2),
        .wr_en              (s_q.word.commit),
        .wr_chan            (s_q.word.chan),
        .wr_data            (s_q.word.data[DW-1:0]),
        .wr_load_now        (s_q.word.load_now),
        .load_all           (s_q.ld),
        .chan_q             (chan_value)
    );

    assign frame_done  = s_q.done;
    assign frame_abort = s_q.abort;
endmodule : qdl_port

// file: testbench/qdl_port_properties.sv
`timescale 1ns/1ps
module qdl_port_properties #(
    parameter int DW = 16,
    parameter int N  = 4
) (
    // clock and reset
    input wire logic            sys_clk,
    input wire logic            rst,
    // pins
    input wire logic            sync_n,
    input wire logic            enable_n,
    input wire logic            load_all_channels,
    input wire logic            reset_scale_select,
    // results
    input wire logic [N*DW-1:0] chan_value,
    input wire logic            frame_done,
    input wire logic            frame_abort
);
    logic [2:0] rc_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // cycles left in which a value change has a cause
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst || frame_done || load_all_channels)
            rc_q <= 3'h7;
        else if (rc_q != 3'h0)
            rc_q <= rc_q - 3'h1;
    end
    a_done_abort_apart: assert property (!(frame_done && frame_abort))
        else $error("done with abort");
    a_done_one_cycle: assert property (frame_done |=> !frame_done)
        else $error("done too long");
    a_abort_one_cycle: assert property (frame_abort |=> !frame_abort)
        else $error("abort too long");
    a_abort_keeps_value: assert property (frame_abort |-> ##1 $stable(chan_value)[*3])
        else $error("abort changed value");
    a_disabled_no_done: assert property (enable_n[*8] |-> !frame_done)
        else $error("done while disabled");
    a_deselect_no_done: assert property (sync_n[*8] |-> !frame_done)
        else $error("done outside frame");
    a_value_has_cause: assert property (!$stable(chan_value) |-> rc_q != 3'h0)
        else $error("value changed alone");
    a_reset_code: assert property ($past(rst, 4) && !$past(rst, 3) |->
        chan_value == {N{reset_scale_select, 15'h0}})
        else $error("bad reset code");
endmodule : qdl_port_properties

// file: testbench/qdl_host.sv
`timescale 1ns/1ps
module qdl_host (
    // clock
    input wire logic sys_clk,
    // serial pins
    output logic     sclk,
    output logic     sync_n,
    output logic     din
);
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end
    // n bits msb first, each taken on a falling edge; clock still between frames
    task automatic send(input logic [23:0] w, input int n);
        sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = w[23-i];
            repeat (4) @(negedge sys_clk);
            sclk = 1'b0;
            repeat (4) @(negedge sys_clk);
            sclk = 1'b1;
        end
        sync_n = 1'b1;
        din = ~din;
        repeat (8) @(negedge sys_clk);
    endtask : send
endmodule : qdl_host

// file: testbench/qdl_port_test.sv
`timescale 1ns/1ps
module qdl_port_test;
    logic sys_clk, rst, sclk, sync_n, din, enable_n, load_all_channels, reset_scale_select;
    logic frame_done, frame_abort;
    logic [63:0] chan_value;
    logic [15:0] act[4], pend[4];
    logic [63:0] q[$];
    int          n_errors = 0;
    int          total_checks = 0;
    int          n_abort = 0;
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    qdl_host host (.sys_clk, .sclk, .sync_n, .din);
    qdl_port DUT (.sys_clk, .rst, .sclk, .sync_n, .din, .enable_n, .load_all_channels,
        .reset_scale_select, .chan_value, .frame_done, .frame_abort);
    function automatic logic [63:0] all_act();
        return {act[3], act[2], act[1], act[0]};
    endfunction : all_act
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic close_out();
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic do_reset(input logic s);
        reset_scale_select = s;
        rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        for (int c = 0; c < 4; c++) begin
            act[c] = {s, 15'h0};
            pend[c] = {s, 15'h0};
        end
        repeat (3) @(negedge sys_clk);
        check("reset code", chan_value, all_act());
    endtask : do_reset
    task automatic wr(input logic [1:0] c, input logic ld);
        logic [15:0] d;
        d = 16'($urandom);
        pend[c] = d ^ {reset_scale_select, 15'h0};
        if (ld)
            act[c] = pend[c];
        q.push_back(all_act());
        host.send({3'h0, ld, 1'b0, c, 1'b0, d}, 24);
    endtask : wr
    // aborts counted where the pulse is settled
    always @(negedge sys_clk) begin
        if (frame_abort === 1'b1)
            n_abort++;
    end
    // one cycle after done the active copy shows the word when its load bit is set; checked a cycle later
    always @(negedge sys_clk) begin
        if (frame_done === 1'b1) begin
            repeat (2) @(negedge sys_clk);
            if (q.size() == 0)
                check("stray done", 64'h1, 64'h0);
            else
                check("channels", chan_value, q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        close_out();
    end
    initial begin
        enable_n = 1'b0;
        load_all_channels = 1'b0;
        void'($urandom(32'h9d0ef50d));
        do_reset(1'b0);
        for (int c = 0; c < 4; c++)
            wr(2'(c), 1'b1);
        host.send(24'h1fffff, 23);
        enable_n = 1'b1;
        host.send(24'h17ffff, 24);
        enable_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        wr(2'h2, 1'b0);
        wr(2'h1, 1'b1);
        act = pend;
        load_all_channels = 1'b1;
        repeat (10) @(negedge sys_clk);
        check("load all", chan_value, all_act());
        load_all_channels = 1'b0;
        do_reset(1'b1);
        wr(2'h3, 1'b1);
        repeat (10) @(negedge sys_clk);
        check("aborts", 64'(n_abort), 64'h1);
        check("notes left", 64'(q.size()), 64'h0);
        close_out();
    end
endmodule : qdl_port_test
bind qdl_port qdl_port_properties #(.DW(DW), .N(N)) u_props (.sys_clk, .rst, .sync_n,
    .enable_n, .load_all_channels, .reset_scale_select, .chan_value, .frame_done,
    .frame_abort);
